//--- core/clk_synth_pkg.sv
package clk_synth_pkg;

	// Register map, byte wide, one register per index
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_SOFT_SEL = 4'h1;
	localparam logic [3:0] OFF_NUM = 4'h2;
	localparam logic [3:0] OFF_DEN = 4'h3;
	localparam logic [3:0] OFF_WD_SEL = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h5;
	localparam logic [3:0] OFF_MASK = 4'h6;
	localparam logic [3:0] OFF_STRAP = 4'h7;

	// Field positions
	localparam int CTRL_OVERRIDE_BIT = 0;
	localparam int DEN_PROG_EN_BIT = 7;
	localparam int ST_WD_EXP_BIT = 0;
	localparam int ST_PD_BIT = 1;
	localparam int ST_WD_ACTIVE_BIT = 2;
	localparam int NUM_W = 7;
	localparam int DEN_W = 6;
	localparam int SEL_W = 5;
	localparam int WD_SEL_W = 4;
	localparam int EV_W = 2;

	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;

	// Gear constants in units of 10 Hz
	localparam logic [23:0] GEAR_LOW = 24'h49_3D06;
	localparam logic [23:0] GEAR_HIGH = 24'h61_A6B3;
	localparam int FREQ_W = 30;

	// Timing
	localparam int CLK_PERIOD_NS = 32'h0000_0028;
	localparam int WD_STEP_NS = 32'h0EE6_B280;
	localparam int WD_STEP_CYCLES = WD_STEP_NS / CLK_PERIOD_NS;
	localparam int PRE_W = 23;
	localparam int RST_PULSE_NS = 32'h0000_07D0;
	localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 6;

	// Output clock half periods in reference cycles: cpu, mid rate, pci
	localparam int NUM_CLK = 3;
	localparam logic [2:0] CLK_HALF [0:2] = '{3'h1, 3'h2, 3'h4};

	typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_PULSE} wd_state_t;
	typedef enum logic [1:0] {PD_RUN, PD_STOPPING, PD_DOWN, PD_LOCK} pd_state_t;

endpackage : clk_synth_pkg

//--- core/clk_out_channel.sv
`timescale 1ns/1ps
module clk_out_channel
(
	input wire logic i_clock, // Reference clock
	input wire logic i_reset, // Synchronous reset
	input wire logic i_run, // Clock allowed to run
	input wire logic [2:0] i_half, // Half period in cycles
	output logic o_clk, // Output clock
	output logic o_clk_comp, // Complement, low when stopped
	output logic o_stopped // Parked low
);
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic clk_reg;
	logic clk_next;
	logic comp_reg;
	logic comp_next;
	logic stop_reg;
	logic stop_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		clk_next = clk_reg;
		stop_next = stop_reg;
		// Park only from the low phase so a high pulse is never cut short
		if (!clk_reg && !i_run)
		begin
			cnt_next = 3'h0;
			stop_next = 1'b1;
		end
		else
		begin
			stop_next = 1'b0;
			if (cnt_reg == i_half - 3'h1)
			begin
				cnt_next = 3'h0;
				clk_next = ~clk_reg;
			end
			else
			begin
				cnt_next = cnt_reg + 3'h1;
			end
		end
		comp_next = stop_next ? 1'b0 : ~clk_next;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			cnt_reg <= 3'h0;
			clk_reg <= 1'b0;
			comp_reg <= 1'b0;
			stop_reg <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_next;
			clk_reg <= clk_next;
			comp_reg <= comp_next;
			stop_reg <= stop_next;
		end
	end

	assign o_clk = clk_reg;
	assign o_clk_comp = comp_reg;
	assign o_stopped = stop_reg;

endmodule : clk_out_channel

//--- core/clock_synth_ctrl.sv
// How it works
// - On a change, frequency switches first, then the watchdog starts counting.
// - Timeout field rewritten to zero before expiry cancels; no reset, new frequency kept.
// - A new soft frequency selection also starts the watchdog.
// - Expiry pulses the system reset output low and sets the expired flag.
// - With programming enabled and a nonzero denominator, cpu frequency is gear times numerator over denominator; otherwise it is the gear.
// - Gear comes from the latched strap select or the soft select.
// - Power-down input is asynchronous and synchronized before use.
// - In power-down all clocks are held low and the PLLs powered down.
// - Clocks stop synchronously with no truncated pulse.
// - After lock all clocks start within two PCI periods of each other.
// - Programming enable is bit seven; zero off, one on.
// - Override clear uses the strap select; set uses the soft select.
// - Numerator is seven bits and denominator six bits, each in its own byte.
`timescale 1ns/1ps
module clock_synth_ctrl
#(
	parameter int WD_STEP_CYCLES = clk_synth_pkg::WD_STEP_CYCLES
)
(
	input wire logic i_clock, // 25 MHz reference-derived clock
	input wire logic i_reset, // Synchronous reset, active high
	input wire logic [clk_synth_pkg::ADDR_W-1:0] i_addr, // Register index
	input wire logic [clk_synth_pkg::DATA_W-1:0] i_wdata, // Write data
	input wire logic i_write, // Write strobe
	input wire logic i_read, // Read strobe
	output logic [clk_synth_pkg::DATA_W-1:0] o_rdata, // Read data, cycle after strobe
	input wire logic [clk_synth_pkg::SEL_W-1:0] i_strap_select, // Strap pins
	input wire logic i_power_down_n, // Asynchronous power-down, active low
	input wire logic i_pll_locked, // PLL lock indication
	output logic o_system_reset_out_n, // System reset pulse, active low
	output logic o_irq, // Interrupt, level
	output logic o_cpu_clk_true, // CPU clock
	output logic o_cpu_clk_comp, // CPU clock complement
	output logic o_mid_rate_clock, // Mid rate clock
	output logic o_pci_clock, // PCI clock
	output logic o_pll_power_down, // Oscillator and PLL power-down
	output logic [clk_synth_pkg::FREQ_W-1:0] o_cpu_freq_word // CPU frequency, 10 Hz units
);
	import clk_synth_pkg::*;

	logic [7:0] ctrl_reg, ctrl_next;
	logic [SEL_W-1:0] soft_sel_reg, soft_sel_next;
	logic [NUM_W-1:0] num_reg, num_next;
	logic [7:0] den_reg, den_next;
	logic [WD_SEL_W-1:0] wd_sel_reg, wd_sel_next;
	logic [EV_W-1:0] status_reg, status_next;
	logic [EV_W-1:0] mask_reg, mask_next;
	logic [SEL_W-1:0] strap_reg, strap_next;
	logic strap_done_reg;
	logic [7:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic pend_reg, pend_next;
	logic change_ev;
	logic [EV_W-1:0] set_vec;
	logic [FREQ_W-1:0] freq_reg, freq_next;
	logic [SEL_W-1:0] sel_src;
	logic [23:0] gear;
	logic [30:0] product;
	logic prog_en;
	wd_state_t wd_state, wd_state_next;
	logic [PRE_W-1:0] pre_reg, pre_next;
	logic [WD_SEL_W-1:0] left_reg, left_next;
	logic [RST_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
	logic rst_n_reg, rst_n_next;
	logic exp_ev;
	logic sync1_reg, sync2_reg;
	pd_state_t pd_state, pd_state_next;
	logic run_reg, run_next;
	logic pll_pd_reg, pll_pd_next;
	logic pd_ev;
	logic [NUM_CLK-1:0] clk_vec, comp_vec, stopped_vec;
	logic wr_hit;

	// Register file
	assign wr_hit = i_write;
	assign prog_en = den_reg[DEN_PROG_EN_BIT];

	always_comb
	begin
		ctrl_next = ctrl_reg;
		soft_sel_next = soft_sel_reg;
		num_next = num_reg;
		den_next = den_reg;
		wd_sel_next = wd_sel_reg;
		mask_next = mask_reg;
		change_ev = 1'b0;
		strap_next = strap_done_reg ? strap_reg : i_strap_select;
		if (wr_hit)
		begin
			unique case (i_addr)
				OFF_CTRL: ctrl_next = {7'h00, i_wdata[CTRL_OVERRIDE_BIT]};
				OFF_SOFT_SEL:
				begin
					soft_sel_next = i_wdata[SEL_W-1:0];
					change_ev = i_wdata[SEL_W-1:0] != soft_sel_reg;
				end
				OFF_NUM:
				begin
					num_next = i_wdata[NUM_W-1:0];
					change_ev = 1'b1;
				end
				OFF_DEN:
				begin
					den_next = {i_wdata[DEN_PROG_EN_BIT], 1'b0, i_wdata[DEN_W-1:0]};
					change_ev = 1'b1;
				end
				OFF_WD_SEL: wd_sel_next = i_wdata[WD_SEL_W-1:0];
				OFF_MASK: mask_next = i_wdata[EV_W-1:0];
				default: ;
			endcase
		end
		set_vec = '0;
		set_vec[ST_WD_EXP_BIT] = exp_ev;
		set_vec[ST_PD_BIT] = pd_ev;
		// Write one to clear; a new event in the same cycle wins
		status_next = status_reg | set_vec;
		if (wr_hit && i_addr == OFF_STATUS)
		begin
			status_next = (status_reg & ~i_wdata[EV_W-1:0]) | set_vec;
		end
		rdata_next = REG_RESET;
		if (i_read)
		begin
			unique case (i_addr)
				OFF_CTRL: rdata_next = ctrl_reg;
				OFF_SOFT_SEL: rdata_next = {3'h0, soft_sel_reg};
				OFF_NUM: rdata_next = {1'b0, num_reg};
				OFF_DEN: rdata_next = den_reg;
				OFF_WD_SEL: rdata_next = {4'h0, wd_sel_reg};
				OFF_STATUS: rdata_next = {5'h00, wd_state == WD_COUNT, status_reg};
				OFF_MASK: rdata_next = {6'h00, mask_reg};
				OFF_STRAP: rdata_next = {3'h0, strap_reg};
				default: rdata_next = REG_RESET;
			endcase
		end
		irq_next = |(status_next & mask_next);
		pend_next = change_ev;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			ctrl_reg <= REG_RESET;
			soft_sel_reg <= '0;
			num_reg <= '0;
			den_reg <= REG_RESET;
			wd_sel_reg <= '0;
			status_reg <= '0;
			mask_reg <= '0;
			strap_reg <= '0;
			strap_done_reg <= 1'b0;
			rdata_reg <= REG_RESET;
			irq_reg <= 1'b0;
			pend_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			soft_sel_reg <= soft_sel_next;
			num_reg <= num_next;
			den_reg <= den_next;
			wd_sel_reg <= wd_sel_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			strap_reg <= strap_next;
			strap_done_reg <= 1'b1;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			pend_reg <= pend_next;
		end
	end

	// Frequency word
	always_comb
	begin
		sel_src = ctrl_reg[CTRL_OVERRIDE_BIT] ? soft_sel_reg : strap_reg;
		gear = sel_src[0] ? GEAR_HIGH : GEAR_LOW;
		product = {7'h00, gear} * {24'h00_0000, num_reg};
		freq_next = {6'h00, gear};
		if (prog_en && den_reg[DEN_W-1:0] != 6'h00)
		begin
			freq_next = FREQ_W'(product / {25'h000_0000, den_reg[DEN_W-1:0]});
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			freq_reg <= '0;
		else
			freq_reg <= freq_next;
	end

	// Watchdog; armed on the same edge that the frequency word takes the change
	always_comb
	begin
		wd_state_next = wd_state;
		pre_next = pre_reg;
		left_next = left_reg;
		rst_cnt_next = rst_cnt_reg;
		rst_n_next = rst_n_reg;
		exp_ev = 1'b0;
		unique case (wd_state)
			WD_IDLE:
			begin
				if (pend_reg && wd_sel_reg != '0)
				begin
					wd_state_next = WD_COUNT;
					pre_next = '0;
					left_next = wd_sel_reg;
				end
			end
			WD_COUNT:
			begin
				if (wd_sel_reg == '0)
				begin
					wd_state_next = WD_IDLE;
				end
				else if (pend_reg)
				begin
					pre_next = '0;
					left_next = wd_sel_reg;
				end
				else if (pre_reg == PRE_W'(WD_STEP_CYCLES - 1))
				begin
					pre_next = '0;
					left_next = left_reg - 4'h1;
					if (left_reg == 4'h1)
					begin
						wd_state_next = WD_PULSE;
						rst_n_next = 1'b0;
						rst_cnt_next = '0;
						exp_ev = 1'b1;
					end
				end
				else
				begin
					pre_next = pre_reg + 23'h00_0001;
				end
			end
			WD_PULSE:
			begin
				rst_cnt_next = rst_cnt_reg + 6'h01;
				if (rst_cnt_reg == RST_CNT_W'(RST_PULSE_CYCLES - 1))
				begin
					rst_n_next = 1'b1;
					wd_state_next = WD_IDLE;
				end
			end
			default: wd_state_next = WD_IDLE;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			wd_state <= WD_IDLE;
			pre_reg <= '0;
			left_reg <= '0;
			rst_cnt_reg <= '0;
			rst_n_reg <= 1'b1;
		end
		else
		begin
			wd_state <= wd_state_next;
			pre_reg <= pre_next;
			left_reg <= left_next;
			rst_cnt_reg <= rst_cnt_next;
			rst_n_reg <= rst_n_next;
		end
	end

	// Power-down sequencing
	always_comb
	begin
		pd_state_next = pd_state;
		run_next = run_reg;
		pll_pd_next = pll_pd_reg;
		pd_ev = 1'b0;
		unique case (pd_state)
			PD_RUN:
			begin
				if (!sync2_reg)
				begin
					pd_state_next = PD_STOPPING;
					run_next = 1'b0;
					pd_ev = 1'b1;
				end
			end
			PD_STOPPING:
			begin
				if (&stopped_vec)
				begin
					pd_state_next = PD_DOWN;
					pll_pd_next = 1'b1;
				end
			end
			PD_DOWN:
			begin
				if (sync2_reg)
				begin
					pd_state_next = PD_LOCK;
					pll_pd_next = 1'b0;
				end
			end
			PD_LOCK:
			begin
				if (!sync2_reg)
				begin
					pd_state_next = PD_DOWN;
					pll_pd_next = 1'b1;
				end
				else if (i_pll_locked)
				begin
					pd_state_next = PD_RUN;
					run_next = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			pd_state <= PD_RUN;
			run_reg <= 1'b1;
			pll_pd_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= i_power_down_n;
			sync2_reg <= sync1_reg;
			pd_state <= pd_state_next;
			run_reg <= run_next;
			pll_pd_reg <= pll_pd_next;
		end
	end

	// One shared run signal keeps every output start in the same cycle
	genvar g;
	generate
		for (g = 0; g < NUM_CLK; g++)
		begin : gen_clk
			clk_out_channel u_chan
			(
				.i_clock(i_clock),
				.i_reset(i_reset),
				.i_run(run_reg),
				.i_half(CLK_HALF[g]),
				.o_clk(clk_vec[g]),
				.o_clk_comp(comp_vec[g]),
				.o_stopped(stopped_vec[g])
			);
		end
	endgenerate

	assign o_rdata = rdata_reg;
	assign o_system_reset_out_n = rst_n_reg;
	assign o_irq = irq_reg;
	assign o_cpu_clk_true = clk_vec[0];
	assign o_cpu_clk_comp = comp_vec[0];
	assign o_mid_rate_clock = clk_vec[1];
	assign o_pci_clock = clk_vec[2];
	assign o_pll_power_down = pll_pd_reg;
	assign o_cpu_freq_word = freq_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	wd_arm_a: assert property (wd_state == WD_IDLE && pend_reg && wd_sel_reg != '0
		|=> wd_state == WD_COUNT && left_reg == $past(wd_sel_reg) && pre_reg == '0)
		else $error("watchdog did not arm after change");
	wd_cancel_a: assert property (wd_state == WD_COUNT && wd_sel_reg == '0
		|=> (wd_state == WD_IDLE && o_system_reset_out_n) ##1 o_system_reset_out_n)
		else $error("watchdog cancel failed");
	soft_sel_trig_a: assert property (i_write && i_addr == OFF_SOFT_SEL
		&& i_wdata[SEL_W-1:0] != soft_sel_reg |=> pend_reg)
		else $error("soft select change did not trigger");
	reset_flag_a: assert property ($fell(o_system_reset_out_n)
		|-> wd_state == WD_PULSE ##0 status_reg[ST_WD_EXP_BIT])
		else $error("reset pulse without expired flag");
	pulse_end_a: assert property (wd_state == WD_PULSE
		&& rst_cnt_reg == RST_CNT_W'(RST_PULSE_CYCLES - 1) |=> o_system_reset_out_n)
		else $error("reset pulse length wrong");
	ratio_two_a: assert property (prog_en && num_reg != '0
		&& {1'b0, den_reg[DEN_W-1:0], 1'b0} == {1'b0, num_reg}
		|=> o_cpu_freq_word == FREQ_W'({$past(gear), 1'b0}))
		else $error("frequency equation wrong");
	// Sampled reset keeps the attempt at the release edge from seeing stale values
	gear_src_a: assert property (!i_reset && !prog_en && !ctrl_reg[CTRL_OVERRIDE_BIT]
		|=> o_cpu_freq_word == ($past(strap_reg[0]) ? {6'h00, GEAR_HIGH} : {6'h00, GEAR_LOW}))
		else $error("gear source wrong");
	pd_entry_a: assert property (pd_state == PD_RUN && !sync2_reg |=> !run_reg)
		else $error("power-down not taken");
	pd_low_a: assert property (pd_state == PD_DOWN
		|-> o_pll_power_down && !o_cpu_clk_true && !o_mid_rate_clock && !o_pci_clock)
		else $error("clocks not low in power-down");
	no_glitch_a: assert property (!run_reg && $rose(o_mid_rate_clock) |=> o_mid_rate_clock)
		else $error("truncated pulse on stop");
	restart_a: assert property (pd_state == PD_LOCK && sync2_reg && i_pll_locked
		|=> run_reg ##1 stopped_vec == '0)
		else $error("outputs did not start together");
	wd_idle_a: assert property (wd_state == WD_IDLE && wd_sel_reg == '0
		|=> wd_state == WD_IDLE)
		else $error("watchdog ran with zero timeout");

endmodule : clock_synth_ctrl

//--- test/pll_lock_model.sv
`timescale 1ns/1ps
module pll_lock_model
#(
	parameter int LOCK_CYCLES = 6
)
(
	input wire logic i_clock, // Reference clock
	input wire logic i_reset, // Synchronous reset
	input wire logic i_pll_power_down, // Oscillator and PLL off
	output logic o_pll_locked // Lock indication
);
	int count_reg;
	// Lock lost at once on power-down, regained after a settle time
	always_ff @(posedge i_clock)
	begin
		if (i_pll_power_down)
			count_reg <= 0;
		else if (i_reset)
			count_reg <= LOCK_CYCLES;
		else if (count_reg < LOCK_CYCLES)
			count_reg <= count_reg + 1;
	end
	assign o_pll_locked = (count_reg == LOCK_CYCLES);
endmodule : pll_lock_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import clk_synth_pkg::*;
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_write = 1'b0;
	logic i_read = 1'b0;
	logic i_power_down_n = 1'b1;
	logic [7:0] rdata;
	logic locked, rst_n, irq, cpu_t, cpu_c, mid, pci, pll_pd;
	logic [FREQ_W-1:0] freq;
	int bad_count = 0;
	int tests_run = 0;
	int hi_mid = 0;
	int hi_pci = 0;

	always #20 i_clock = ~i_clock;

	clock_synth_ctrl #(.WD_STEP_CYCLES(4)) DUT (.i_clock(i_clock), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
		.o_rdata(rdata), .i_strap_select(5'h01), .i_power_down_n(i_power_down_n),
		.i_pll_locked(locked), .o_system_reset_out_n(rst_n), .o_irq(irq),
		.o_cpu_clk_true(cpu_t), .o_cpu_clk_comp(cpu_c), .o_mid_rate_clock(mid),
		.o_pci_clock(pci), .o_pll_power_down(pll_pd), .o_cpu_freq_word(freq));

	pll_lock_model pll (.i_clock(i_clock), .i_reset(i_reset), .i_pll_power_down(pll_pd),
		.o_pll_locked(locked));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	// High phases must be whole, also when stopping
	always @(posedge i_clock)
	begin
		#1;
		if (mid === 1'b1)
			hi_mid++;
		else
		begin
			if (hi_mid != 0)
				chk(hi_mid, 2);
			hi_mid = 0;
		end
		if (pci === 1'b1)
			hi_pci++;
		else
		begin
			if (hi_pci != 0)
				chk(hi_pci, 4);
			hi_pci = 0;
		end
	end

	task automatic t_regs();
		logic [7:0] d;
		rd(OFF_STATUS, d);
		chk(d, 8'h00);
		chk(rst_n, 1'b1);
		wr(OFF_STRAP, 8'h1E);
		wr(4'h8, 8'hFF);
		rd(OFF_STRAP, d);
		chk(d, 8'h01);
		rd(4'h8, d);
		chk(d, 8'h00);
		$display("test regs done");
	endtask : t_regs

	task automatic t_freq();
		logic [7:0] d;
		wr(OFF_NUM, 8'hFF);
		rd(OFF_NUM, d);
		chk(d, 8'h7F);
		wr(OFF_NUM, 8'h50);
		wr(OFF_DEN, 8'hE8);
		rd(OFF_DEN, d);
		chk(d, 8'hA8);
		cyc(3);
		chk(32'(freq), 32'(GEAR_HIGH) * 2);
		wr(OFF_CTRL, 8'h01);
		wr(OFF_DEN, 8'hB0);
		wr(OFF_NUM, 8'h60);
		cyc(3);
		chk(32'(freq), 32'(GEAR_LOW) * 2);
		wr(OFF_DEN, 8'h30);
		cyc(3);
		chk(32'(freq), 32'(GEAR_LOW));
		rd(OFF_STATUS, d);
		chk(d, 8'h00);
		chk(rst_n, 1'b1);
		$display("test freq done");
	endtask : t_freq

	task automatic t_wd();
		logic [7:0] d;
		int n;
		wr(OFF_MASK, 8'h01);
		wr(OFF_WD_SEL, 8'h02);
		wr(OFF_NUM, 8'h64);
		n = 0;
		while (rst_n === 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		chk(n >= 6 && n <= 14, 1);
		n = 0;
		while (rst_n === 1'b0 && n < 100)
		begin
			cyc(1);
			n++;
		end
		chk(n, RST_PULSE_CYCLES);
		rd(OFF_STATUS, d);
		chk(d, 8'h01);
		chk(irq, 1'b1);
		wr(OFF_STATUS, 8'h01);
		cyc(2);
		chk(irq, 1'b0);
		wr(OFF_WD_SEL, 8'h00);
		$display("test watchdog done");
	endtask : t_wd

	task automatic t_cancel();
		logic [7:0] d;
		int n;
		wr(OFF_WD_SEL, 8'h03);
		wr(OFF_SOFT_SEL, 8'h01);
		rd(OFF_STATUS, d);
		chk(d, 8'h04);
		wr(OFF_WD_SEL, 8'h00);
		n = 0;
		repeat (40)
		begin
			cyc(1);
			n += (rst_n !== 1'b1);
		end
		chk(n, 0);
		rd(OFF_STATUS, d);
		chk(d, 8'h00);
		chk(32'(freq), 32'(GEAR_HIGH));
		$display("test cancel done");
	endtask : t_cancel

	task automatic t_pd();
		int n;
		int t[3];
		int lo;
		int hi;
		wr(OFF_MASK, 8'h00);
		i_power_down_n <= 1'b0;
		n = 0;
		while (pll_pd !== 1'b1 && n < 30)
		begin
			cyc(1);
			n++;
		end
		chk(n >= 3 && n <= 12, 1);
		repeat (8)
		begin
			cyc(1);
			chk({cpu_t, cpu_c, mid, pci, pll_pd}, 5'h01);
		end
		chk(irq, 1'b0);
		wr(OFF_MASK, 8'h02);
		cyc(2);
		chk(irq, 1'b1);
		wr(OFF_STATUS, 8'h02);
		cyc(2);
		chk(irq, 1'b0);
		@(posedge i_clock);
		i_power_down_n <= 1'b1;
		t = '{-1, -1, -1};
		for (int k = 0; k < 60; k++)
		begin
			cyc(1);
			if (cpu_t === 1'b1 && t[0] < 0)
				t[0] = k;
			if (mid === 1'b1 && t[1] < 0)
				t[1] = k;
			if (pci === 1'b1 && t[2] < 0)
				t[2] = k;
		end
		lo = 99;
		hi = -1;
		foreach (t[i])
		begin
			lo = (t[i] < lo) ? t[i] : lo;
			hi = (t[i] > hi) ? t[i] : hi;
		end
		chk(lo >= 0 && hi - lo <= 16, 1);
		$display("test power-down done");
	endtask : t_pd

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (20000) @(posedge i_clock);
		bad_count++;
		$display("unexpected at %0t: got %h expected %h", $time, 0, 1);
		summarize();
	end

	initial
	begin
		repeat (4) @(posedge i_clock);
		i_reset <= 1'b0;
		cyc(2);
		t_regs();
		t_freq();
		t_wd();
		t_cancel();
		t_pd();
		summarize();
	end
endmodule : tb_top
